/* rtl/sdo_expedited_server.sv */
// Node-side expedited service-data server with boot announcement.
// Assumes a CAN controller on the same clock with valid/ready frame
// ports (byte 0 in data bits 7..0) and an Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none
module sdo_expedited_server (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [10:0] txId,
  output logic [3:0] txDlc,
  output logic [63:0] txData,
  input wire logic txReady
);
  typedef enum {ST_IDLE, ST_LOOK, ST_SEND} sdo_state_t;

  logic rstMeta;
  logic rstSync;
  sdo_state_t state, next_state;
  logic bootSent, next_bootSent;
  logic [63:0] req, next_req;
  logic [7:0] served, next_served;
  logic [7:0] refused, next_refused;
  logic next_rxReady, next_txValid;
  logic [10:0] next_txId;
  logic [3:0] next_txDlc;
  logic [63:0] next_txData;
  logic [31:0] ctrl, next_ctrl;
  logic [2:0] slot, next_slot;
  logic [31:0] next_avsReadData;
  logic next_avsWaitRequest;
  logic enable;
  logic [10:0] nodeId;
  logic isUpload, isDownload, isExpedited;
  logic [7:0] upCmd;
  logic [31:0] maskedValue;
  logic sizeOk, upOk, dlOk, busTake;

  sdo_dict_if dict ();

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  sdo_dict u_dict (
    .clock(clock),
    .rstn(rstSync),
    .dict(dict)
  );

  sdo_cmd_decode u_decode (
    .cmdByte(req[7:0]),
    .entrySize(dict.lkSize),
    .entryValue(dict.lkValue),
    .reqValue(req[63:32]),
    .isUpload(isUpload),
    .isDownload(isDownload),
    .isExpedited(isExpedited),
    .upCmd(upCmd),
    .maskedValue(maskedValue)
  );

  // Lookup key from the held request: index bytes 1..2, subindex byte 3
  assign dict.lkIndex = req[23:8];
  assign dict.lkSub = req[31:24];
  assign enable = ctrl[sdo_pkg::CTRL_EN_BIT];
  assign nodeId = {4'h0, ctrl[sdo_pkg::CTRL_NODE_LSB+6:sdo_pkg::CTRL_NODE_LSB]};
  // Large entries cannot travel expedited
  assign sizeOk = dict.lkSize != sdo_pkg::SIZE_LARGE
    && dict.lkSize <= sdo_pkg::MAX_EXP_BYTES;
  assign upOk = isUpload && dict.lkHit && sizeOk;
  assign dlOk = isDownload && isExpedited && dict.lkHit && sizeOk;
  assign dict.sdoWr = state == ST_LOOK && dlOk;
  assign dict.sdoData = maskedValue;

  // Boot frame, request intake, reply building
  always_comb begin
    next_state = state;
    next_bootSent = bootSent;
    next_req = req;
    next_served = served;
    next_refused = refused;
    next_txValid = txValid;
    next_txId = txId;
    next_txDlc = txDlc;
    next_txData = txData;
    case (state)
      ST_IDLE: begin
        if (enable && !bootSent) begin
          next_bootSent = 1'b1;
          next_txValid = 1'b1;
          next_txId = sdo_pkg::BOOT_BASE + nodeId;
          next_txDlc = sdo_pkg::BOOT_DLC;
          next_txData = {56'h0, sdo_pkg::BOOT_BYTE};
          next_state = ST_SEND;
        end else if (rxValid && rxReady && rxDlc == sdo_pkg::FRAME_DLC
            && rxId == sdo_pkg::REQ_BASE + nodeId) begin
          next_req = rxData;
          next_state = ST_LOOK;
        end
      end
      ST_LOOK: begin
        next_txId = sdo_pkg::RSP_BASE + nodeId;
        next_txDlc = sdo_pkg::FRAME_DLC;
        if (upOk) begin
          next_txData = {maskedValue, req[31:8], upCmd};
          next_txValid = 1'b1;
          next_served = served + 8'h01;
          next_state = ST_SEND;
        end else if (dlOk) begin
          next_txData = {32'h0, req[31:8], sdo_pkg::SCS_DOWNLOAD, 5'h00};
          next_txValid = 1'b1;
          next_served = served + 8'h01;
          next_state = ST_SEND;
        end else begin
          next_refused = refused + 8'h01;
          next_state = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (txReady) begin
          next_txValid = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_rxReady = next_state == ST_IDLE && enable && next_bootSent;
  end

  // Server state registers
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      state <= ST_IDLE;
      bootSent <= 1'b0;
      req <= '0;
      served <= '0;
      refused <= '0;
      rxReady <= 1'b0;
      txValid <= 1'b0;
      txId <= '0;
      txDlc <= '0;
      txData <= '0;
    end else begin
      state <= next_state;
      bootSent <= next_bootSent;
      req <= next_req;
      served <= next_served;
      refused <= next_refused;
      rxReady <= next_rxReady;
      txValid <= next_txValid;
      txId <= next_txId;
      txDlc <= next_txDlc;
      txData <= next_txData;
    end
  end

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] oldWord,
      input logic [31:0] newWord, input logic [3:0] be);
    logic [31:0] res;
    res = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b+:8] = newWord[8*b+:8];
      end
    end
    return res;
  endfunction

  // Bus slave: one wait cycle, access taken when waitrequest is low
  assign busTake = (avsRead || avsWrite) && !avsWaitRequest;
  assign dict.swSlot = slot;
  assign dict.swKeyWr = busTake && avsWrite && avsAddress == sdo_pkg::REG_KEY;
  assign dict.swValWr = busTake && avsWrite && avsAddress == sdo_pkg::REG_VALUE;
  assign dict.swData = avsAddress == sdo_pkg::REG_KEY
    ? merge(dict.swKey, avsWriteData, avsByteEnable)
    : merge(dict.swValue, avsWriteData, avsByteEnable);

  always_comb begin
    next_ctrl = ctrl;
    next_slot = slot;
    next_avsWaitRequest = !((avsRead || avsWrite) && avsWaitRequest);
    next_avsReadData = avsReadData;
    if (busTake && avsWrite && avsAddress == sdo_pkg::REG_CTRL) begin
      next_ctrl = merge(ctrl, avsWriteData, avsByteEnable);
    end
    if (busTake && avsWrite && avsAddress == sdo_pkg::REG_SLOT
        && avsByteEnable[0]) begin
      next_slot = avsWriteData[2:0];
    end
    if (avsRead && avsWaitRequest) begin
      case (avsAddress)
        sdo_pkg::REG_CTRL: next_avsReadData = ctrl;
        sdo_pkg::REG_STATUS: next_avsReadData = {8'h00, refused, served,
          6'h00, state != ST_IDLE, bootSent};
        sdo_pkg::REG_SLOT: next_avsReadData = {29'h0, slot};
        sdo_pkg::REG_KEY: next_avsReadData = dict.swKey;
        sdo_pkg::REG_VALUE: next_avsReadData = dict.swValue;
        default: next_avsReadData = 32'h0000_0000;
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      ctrl <= sdo_pkg::CTRL_RESET;
      slot <= '0;
      avsWaitRequest <= 1'b1;
      avsReadData <= '0;
    end else begin
      ctrl <= next_ctrl;
      slot <= next_slot;
      avsWaitRequest <= next_avsWaitRequest;
      avsReadData <= next_avsReadData;
    end
  end

  // Checks on the frames the node sends, the table write and the bus answer
  a_boot_frame: assert property (@(posedge clock) disable iff (!rstSync)
    state == ST_IDLE && enable && !bootSent |=> txValid
    && txId == sdo_pkg::BOOT_BASE + nodeId && txDlc == sdo_pkg::BOOT_DLC
    && txData[7:0] == sdo_pkg::BOOT_BYTE)
    else $error("boot frame wrong");
  a_boot_once: assert property (@(posedge clock) disable iff (!rstSync)
    bootSent && !txValid
    |=> bootSent && !(txValid && txId[10:8] == 3'h7))
    else $error("second boot frame");
  a_store_entry: assert property (@(posedge clock) disable iff (!rstSync)
    state == ST_LOOK && dlOk |-> dict.sdoWr
    ##1 txValid && txData[7:0] == {sdo_pkg::SCS_DOWNLOAD, 5'h00})
    else $error("download not stored or answered");
  a_one_reply: assert property (@(posedge clock) disable iff (!rstSync)
    state == ST_LOOK && upOk |=> txValid && state == ST_SEND
    && txData[63:32] == $past(maskedValue))
    else $error("upload reply missing");
  a_large_refused: assert property (@(posedge clock) disable iff (!rstSync)
    state == ST_LOOK && dict.lkSize == sdo_pkg::SIZE_LARGE
    |=> !txValid && refused == $past(refused) + 8'h01)
    else $error("large entry answered");
  a_reply_id: assert property (@(posedge clock) disable iff (!rstSync)
    txValid && txDlc == sdo_pkg::FRAME_DLC
    |-> txId == sdo_pkg::RSP_BASE + nodeId)
    else $error("reply id wrong");
  a_unused_zero: assert property (@(posedge clock) disable iff (!rstSync)
    txValid && txDlc == sdo_pkg::FRAME_DLC |-> !txData[4])
    else $error("unused command bit set");
  a_upload_flags: assert property (@(posedge clock) disable iff (!rstSync)
    txValid && txData[7:5] == sdo_pkg::SCS_UPLOAD |-> txData[1:0] == 2'b11
    && txData[3:2] == 2'(sdo_pkg::MAX_EXP_BYTES - $past(dict.lkSize, 1))
    || $past(txValid))
    else $error("upload flags wrong");
  a_count_gated: assert property (@(posedge clock) disable iff (!rstSync)
    txValid && txDlc == sdo_pkg::FRAME_DLC && txData[1:0] != 2'b11
    |-> txData[3:2] == 2'b00)
    else $error("count without flags");
  a_tx_hold: assert property (@(posedge clock) disable iff (!rstSync)
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txId))
    else $error("frame dropped before taken");
  a_bus_answer: assert property (@(posedge clock) disable iff (!rstSync)
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer late");

  c_boot: cover property (@(posedge clock) disable iff (!rstSync)
    $rose(bootSent));
  c_upload: cover property (@(posedge clock) disable iff (!rstSync)
    state == ST_LOOK && upOk);
  c_download: cover property (@(posedge clock) disable iff (!rstSync)
    dict.sdoWr);
  c_refused: cover property (@(posedge clock) disable iff (!rstSync)
    state == ST_LOOK && !upOk && !dlOk);
endmodule
`default_nettype wire

/* rtl/sdo_pkg.sv */
// Shared constants for the expedited service-data server.
// Assumes a 50 MHz system clock and 32-bit Avalon-MM register access.
package sdo_pkg;
  // Frame identifiers and fixed frame contents
  localparam logic [10:0] BOOT_BASE = 11'h700;
  localparam logic [10:0] REQ_BASE = 11'h600;
  localparam logic [10:0] RSP_BASE = 11'h580;
  localparam logic [7:0] BOOT_BYTE = 8'h00;
  localparam logic [3:0] BOOT_DLC = 4'h1;
  localparam logic [3:0] FRAME_DLC = 4'h8;
  // Command specifiers in byte 0 bits 7..5
  localparam logic [2:0] CCS_DOWNLOAD = 3'h1;
  localparam logic [2:0] CCS_UPLOAD = 3'h2;
  localparam logic [2:0] SCS_UPLOAD = 3'h2;
  localparam logic [2:0] SCS_DOWNLOAD = 3'h3;
  localparam int CMD_CS_LSB = 5;
  localparam int CMD_N_LSB = 2;
  localparam int CMD_E_BIT = 1;
  localparam int CMD_S_BIT = 0;
  // Entry sizes: 1..4 bytes travel expedited, 0 marks a large entry
  localparam logic [2:0] MAX_EXP_BYTES = 3'h4;
  localparam logic [2:0] SIZE_LARGE = 3'h0;
  localparam int DICT_DEPTH = 8;
  localparam int DICT_AW = 3;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_SLOT = 5'h08;
  localparam logic [4:0] REG_KEY = 5'h0c;
  localparam logic [4:0] REG_VALUE = 5'h10;
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NODE_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int KEY_SUB_LSB = 16;
  localparam int KEY_SIZE_LSB = 24;
  localparam int STAT_SERVED_LSB = 8;
  localparam int STAT_REFUSED_LSB = 16;
endpackage

/* rtl/sdo_dict_if.sv */
// Connection between the server core and its entry table.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface sdo_dict_if;
  logic [15:0] lkIndex;
  logic [7:0] lkSub;
  logic lkHit;
  logic [2:0] lkSize;
  logic [31:0] lkValue;
  logic sdoWr;
  logic [31:0] sdoData;
  logic [2:0] swSlot;
  logic swKeyWr;
  logic swValWr;
  logic [31:0] swData;
  logic [31:0] swKey;
  logic [31:0] swValue;
  modport server (
    output lkIndex, lkSub, sdoWr, sdoData, swSlot, swKeyWr, swValWr, swData,
    input lkHit, lkSize, lkValue, swKey, swValue
  );
  modport table_side (
    input lkIndex, lkSub, sdoWr, sdoData, swSlot, swKeyWr, swValWr, swData,
    output lkHit, lkSize, lkValue, swKey, swValue
  );
endinterface
`default_nettype wire

/* rtl/sdo_dict.sv */
// Entry table: key, size and value per slot, with a lookup port.
// Assumes a synchronised active-low reset from the top module.
`timescale 1ns/1ns
`default_nettype none
module sdo_dict (
  input wire logic clock,
  input wire logic rstn,
  sdo_dict_if.table_side dict
);
  logic [31:0] keyMem [sdo_pkg::DICT_DEPTH];
  logic [31:0] valMem [sdo_pkg::DICT_DEPTH];
  logic [31:0] next_keyMem [sdo_pkg::DICT_DEPTH];
  logic [31:0] next_valMem [sdo_pkg::DICT_DEPTH];
  logic [sdo_pkg::DICT_DEPTH-1:0] hitVec;
  logic [sdo_pkg::DICT_AW-1:0] hitSlot;

  // Per-slot key compare
  for (genvar i = 0; i < sdo_pkg::DICT_DEPTH; i++) begin : g_cmp
    assign hitVec[i] = keyMem[i][sdo_pkg::KEY_SUB_LSB-1:0] == dict.lkIndex
      && keyMem[i][sdo_pkg::KEY_SIZE_LSB-1:sdo_pkg::KEY_SUB_LSB] == dict.lkSub;
  end

  // Lowest matching slot wins
  always_comb begin
    hitSlot = '0;
    for (int i = sdo_pkg::DICT_DEPTH - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        hitSlot = i[sdo_pkg::DICT_AW-1:0];
      end
    end
  end

  assign dict.lkHit = |hitVec;
  assign dict.lkSize = keyMem[hitSlot][sdo_pkg::KEY_SIZE_LSB+2:sdo_pkg::KEY_SIZE_LSB];
  assign dict.lkValue = valMem[hitSlot];
  assign dict.swKey = keyMem[dict.swSlot];
  assign dict.swValue = valMem[dict.swSlot];

  // Software updates; a network write to the same slot wins
  always_comb begin
    next_keyMem = keyMem;
    next_valMem = valMem;
    if (dict.swKeyWr) begin
      next_keyMem[dict.swSlot] = dict.swData;
    end
    if (dict.swValWr) begin
      next_valMem[dict.swSlot] = dict.swData;
    end
    if (dict.sdoWr) begin
      next_valMem[hitSlot] = dict.sdoData;
    end
  end

  // Table storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < sdo_pkg::DICT_DEPTH; i++) begin
        keyMem[i] <= '0;
        valMem[i] <= '0;
      end
    end else begin
      keyMem <= next_keyMem;
      valMem <= next_valMem;
    end
  end
endmodule
`default_nettype wire

/* rtl/sdo_cmd_decode.sv */
// Command byte decoder and data byte masking for one request.
// Pure combinational; inputs come from registered request data.
`timescale 1ns/1ns
`default_nettype none
module sdo_cmd_decode (
  input wire logic [7:0] cmdByte,
  input wire logic [2:0] entrySize,
  input wire logic [31:0] entryValue,
  input wire logic [31:0] reqValue,
  output logic isUpload,
  output logic isDownload,
  output logic isExpedited,
  output logic [7:0] upCmd,
  output logic [31:0] maskedValue
);
  logic [2:0] dlBytes;
  logic [2:0] count;
  logic [1:0] unusedN;
  logic [31:0] rawValue;

  // Specifier and flags of the request
  assign isUpload = cmdByte[7:sdo_pkg::CMD_CS_LSB] == sdo_pkg::CCS_UPLOAD;
  assign isDownload = cmdByte[7:sdo_pkg::CMD_CS_LSB] == sdo_pkg::CCS_DOWNLOAD;
  assign isExpedited = cmdByte[sdo_pkg::CMD_E_BIT];
  // Byte count meaningful only with both flags set
  assign dlBytes = cmdByte[sdo_pkg::CMD_S_BIT] && isExpedited
    ? sdo_pkg::MAX_EXP_BYTES - {1'b0, cmdByte[sdo_pkg::CMD_N_LSB+1:sdo_pkg::CMD_N_LSB]}
    : sdo_pkg::MAX_EXP_BYTES;
  assign unusedN = 2'(sdo_pkg::MAX_EXP_BYTES - entrySize);
  // Upload reply: expedited, size indicated, unused bits zero
  assign upCmd = {sdo_pkg::SCS_UPLOAD, 1'b0, unusedN, 1'b1, 1'b1};
  assign count = isUpload ? entrySize : dlBytes;
  assign rawValue = isUpload ? entryValue : reqValue;

  // Bytes past the count carry zero
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign maskedValue[8*b+7:8*b] = (3'(b) < count) ? rawValue[8*b+7:8*b]
      : 8'h00;
  end
endmodule
`default_nettype wire

/* test/sdo_master_model.sv */
// Network master model: sends request frames, takes reply frames.
// Assumes the server's frame ports on the same clock as the bench.
`timescale 1ns/1ns
`default_nettype none
module sdo_master_model (
  input wire logic clock,
  output logic rxValid,
  output logic [10:0] rxId,
  output logic [3:0] rxDlc,
  output logic [63:0] rxData,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [10:0] txId,
  input wire logic [3:0] txDlc,
  input wire logic [63:0] txData,
  output logic txReady
);
  int stall;

  // Idle state at time zero
  initial begin
    stall = 0;
    rxValid = 1'b0;
    rxId = 11'h000;
    rxDlc = 4'h0;
    rxData = 64'h0;
    txReady = 1'b0;
  end

  // One whole request frame, held until the server takes it
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
      input logic [63:0] data, output bit ok);
    int i;
    ok = 0;
    rxValid <= 1'b1;
    rxId <= id;
    rxDlc <= dlc;
    rxData <= data;
    for (i = 0; i < 100 && !ok; i++) begin
      @(posedge clock);
      ok = (rxReady === 1'b1);
    end
    // Stale fields are inverted so nothing can lean on them
    rxValid <= 1'b0;
    rxId <= ~id;
    rxDlc <= ~dlc;
    rxData <= ~data;
  endtask

  // One reply frame, taken after a number of stall cycles
  task automatic get(input int lim, output logic [10:0] id,
      output logic [3:0] dlc, output logic [63:0] data, output bit ok);
    int i;
    ok = 0;
    for (i = 0; i < lim && !ok; i++) begin
      @(negedge clock);
      ok = (txValid === 1'b1);
    end
    id = txId;
    dlc = txDlc;
    data = txData;
    if (ok) begin
      repeat (stall) @(negedge clock);
      @(posedge clock);
      txReady <= 1'b1;
      @(negedge clock);
      if (txValid !== 1'b1 || txId !== id || txData !== data) begin
        ok = 0;
      end
    end
    @(posedge clock);
    txReady <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/tb_sdo_expedited_server.sv */
// Self-checking bench for the expedited service-data server.
// Assumes the master model file is compiled before this one.
`timescale 1ns/1ns
`default_nettype none
module tb_sdo_expedited_server;
  logic clock, rstn, avsRead, avsWrite, avsWaitRequest;
  logic [4:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [3:0] avsByteEnable, rxDlc, txDlc;
  logic rxValid, rxReady, txValid, txReady;
  logic [10:0] rxId, txId;
  logic [63:0] rxData, txData;
  logic [6:0] node;
  logic [15:0] idx [6];
  logic [7:0] sub [6];
  logic [31:0] val [6];
  logic [2:0] sz [6];
  logic [7:0] served, refused;
  int n_mismatch, tests_run;

  sdo_expedited_server u_sdo_expedited_server (.clock(clock), .rstn(rstn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .rxValid(rxValid), .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txId(txId), .txDlc(txDlc),
    .txData(txData), .txReady(txReady));

  sdo_master_model u_sdo_master_model (.clock(clock), .rxValid(rxValid),
    .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .rxReady(rxReady),
    .txValid(txValid), .txId(txId), .txDlc(txDlc), .txData(txData),
    .txReady(txReady));

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Frame layout: byte 0 command, index, subindex, data LSB first
  function automatic logic [63:0] frame(input logic [7:0] c,
      input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v);
    return {v, sb, ix, c};
  endfunction

  // Keeps the low n bytes of a value
  function automatic logic [31:0] keep(input logic [31:0] v, input int n);
    return v & 32'((64'h1 << (8 * n)) - 64'h1);
  endfunction

  task automatic test_done();
    $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Avalon-MM access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int i;
    bit done;
    done = 0;
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= wd;
    // Waitrequest and read data are taken at one rising edge
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge clock);
      done = (avsWaitRequest === 1'b0);
      if (done) begin
        rd = avsReadData;
      end
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clock);
    check("bus answer", 1, done);
    if (!done) test_done();
  endtask

  // One request and, if wanted, its reply compared field by field
  task automatic xfer(input logic [10:0] id, input logic [3:0] dlc,
      input logic [63:0] req, input bit want, input logic [63:0] exp);
    logic [10:0] gid;
    logic [3:0] gdlc;
    logic [63:0] gd;
    bit ok;
    u_sdo_master_model.stall = $urandom_range(3, 0);
    u_sdo_master_model.send(id, dlc, req, ok);
    check("frame taken", 1, ok);
    if (!ok) test_done();
    u_sdo_master_model.get(want ? 100 : 12, gid, gdlc, gd, ok);
    check("reply seen", want, ok);
    if (want) begin
      check("reply id", sdo_pkg::RSP_BASE + 11'(node), gid);
      check("reply dlc", sdo_pkg::FRAME_DLC, gdlc);
      check("reply data", exp, gd);
    end
  endtask

  // Main sequence
  initial begin
    logic [31:0] rd, v;
    logic [10:0] gid;
    logic [3:0] gdlc;
    logic [63:0] gd;
    logic [7:0] cmds [5];
    logic [10:0] reqId;
    bit ok;
    int cnt;
    rstn = 1'b0;
    avsAddress = 5'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hf;
    n_mismatch = 0;
    tests_run = 0;
    served = 8'h00;
    refused = 8'h00;
    cmds = '{8'h2f, 8'h2b, 8'h27, 8'h23, 8'h22};
    rd = $urandom(32'h34b7de1b);
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    check("rx ready while disabled", 0, rxReady);
    check("tx idle after reset", 0, txValid);
    // Table set-up: four expedited sizes, one large, one word entry
    node = 7'($urandom_range(127, 1));
    reqId = sdo_pkg::REQ_BASE + 11'(node);
    for (int i = 0; i < 6; i++) begin
      idx[i] = {8'(8'h20 + i), 8'($urandom)};
      sub[i] = 8'($urandom);
      val[i] = $urandom;
      sz[i] = (i < 4) ? 3'(i + 1) : ((i == 4) ? 3'h0 : 3'h4);
      bus(1'b1, sdo_pkg::REG_SLOT, 32'(i), rd);
      bus(1'b1, sdo_pkg::REG_KEY, {5'h00, sz[i], sub[i], idx[i]}, rd);
      bus(1'b1, sdo_pkg::REG_VALUE, val[i], rd);
    end
    bus(1'b0, sdo_pkg::REG_KEY, 32'h0, rd);
    check("key readback", {5'h00, sz[5], sub[5], idx[5]}, rd);
    bus(1'b0, 5'h14, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    // Enable with node number; boot frame must follow
    bus(1'b1, sdo_pkg::REG_CTRL, {17'h0, node, 7'h00, 1'b1}, rd);
    u_sdo_master_model.get(50, gid, gdlc, gd, ok);
    check("boot seen", 1, ok);
    check("boot id", 11'h700 + 11'(node), gid);
    check("boot dlc", 4'h1, gdlc);
    check("boot byte", 8'h00, gd[7:0]);
    bus(1'b0, sdo_pkg::REG_STATUS, 32'h0, rd);
    check("boot flag", 1, rd[0]);
    // Uploads of each expedited size, back to back
    for (int i = 0; i < 4; i++) begin
      xfer(reqId, 4'h8, frame(8'h40, idx[i], sub[i], 32'h0), 1,
        frame({3'h2, 1'b0, 2'(4 - sz[i]), 2'b11}, idx[i], sub[i],
        keep(val[i], sz[i])));
      served++;
    end
    // Downloads in every expedited command form, each read back
    for (int k = 0; k < 5; k++) begin
      v = $urandom;
      cnt = (cmds[k][1:0] == 2'b11) ? 4 - cmds[k][3:2] : 4;
      xfer(reqId, 4'h8, frame(cmds[k], idx[5], sub[5], v), 1,
        frame(8'h60, idx[5], sub[5], 32'h0));
      xfer(reqId, 4'h8, frame(8'h40, idx[5], sub[5], 32'h0), 1,
        frame(8'h43, idx[5], sub[5], keep(v, cnt)));
      served += 2;
    end
    // Refusals: large entry both ways, normal type, bad specifier, missing
    xfer(reqId, 4'h8, frame(8'h40, idx[4], sub[4], 32'h0), 0, 0);
    xfer(reqId, 4'h8, frame(8'h23, idx[4], sub[4], v), 0, 0);
    xfer(reqId, 4'h8, frame(8'h20, idx[5], sub[5], v), 0, 0);
    xfer(reqId, 4'h8, frame(8'h80, idx[5], sub[5], v), 0, 0);
    xfer(reqId, 4'h8, frame(8'h40, 16'h1fff, 8'h00, 32'h0), 0, 0);
    refused += 5;
    // Frames for another node or too short are dropped silently
    xfer(reqId + 11'h001, 4'h8, frame(8'h40, idx[0], sub[0], 0), 0, 0);
    xfer(reqId, 4'h4, frame(8'h40, idx[0], sub[0], 32'h0), 0, 0);
    bus(1'b0, sdo_pkg::REG_STATUS, 32'h0, rd);
    check("served count", served, rd[15:8]);
    check("refused count", refused, rd[23:16]);
    check("not busy", 0, rd[1]);
    test_done();
  end
endmodule
`default_nettype wire
